// *** alu_byte_math.sv ***
`timescale 1ns/1ps
`include "alu_cfg.svh"
module alu_byte_math
  import alu_pkg::*;
#(
  parameter int W = 8
)
(
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic carry_in,
  input wire logic subtract,
  // Results
  output logic [W-1:0] result,
  output logic carry_out,
  output logic half_out,
  output logic overflow_out
);
  logic [W:0] wide;
  logic [`ALU_NIB_W:0] low_nib;

  always_comb
  begin
    if (subtract)
    begin
      wide = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, carry_in};
      low_nib = {1'b0, a[`ALU_NIB_W-1:0]} - {1'b0, b[`ALU_NIB_W-1:0]}
        - {{`ALU_NIB_W{1'b0}}, carry_in};
    end
    else
    begin
      wide = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, carry_in};
      low_nib = {1'b0, a[`ALU_NIB_W-1:0]} + {1'b0, b[`ALU_NIB_W-1:0]}
        + {{`ALU_NIB_W{1'b0}}, carry_in};
    end
    result = wide[W-1:0];
    // Borrow reads as the same top bit as carry in this form
    carry_out = wide[W];
    half_out = low_nib[`ALU_NIB_W];
    if (subtract)
      overflow_out = (a[W-1] != b[W-1]) && (wide[W-1] != a[W-1]);
    else
      overflow_out = (a[W-1] == b[W-1]) && (wide[W-1] != a[W-1]);
  end
endmodule

// *** alu_cfg.svh ***
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define ALU_IO_BIT_MAX 5'h1F
`define ALU_NIB_W 4
`define ALU_IO_ADDR_W 6
`define ALU_FLAG_C 0
`define ALU_FLAG_Z 1
`define ALU_FLAG_N 2
`define ALU_FLAG_V 3
`define ALU_FLAG_S 4
`define ALU_FLAG_H 5
`define ALU_FLAGS_RESET 6'h00
`endif

// *** alu_datapath.sv ***
`timescale 1ns/1ps
`include "alu_cfg.svh"
module alu_datapath
  import alu_pkg::*;
#(
  parameter int W = 8,
  parameter int IOW = `ALU_IO_ADDR_W
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Decoder request
  input wire logic op_valid,
  input wire alu_op_t op_code,
  input wire logic use_constant,
  input wire logic [W-1:0] constant,
  input wire logic [2:0] bit_sel,
  input wire logic [IOW-1:0] io_addr,
  // Register file operands
  input wire logic [W-1:0] dest_value,
  input wire logic [W-1:0] source_register,
  input wire logic [W-1:0] pair_high,
  // I/O register read value and its write-one-to-clear mask
  input wire logic [W-1:0] io_read_data,
  input wire logic [W-1:0] io_w1c_mask,
  // Register file write
  output logic reg_we,
  output logic reg_we_high,
  output logic [W-1:0] reg_wdata,
  // I/O write
  output logic io_we,
  output logic [IOW-1:0] io_waddr,
  output logic [W-1:0] io_wdata,
  output logic [W-1:0] io_wmask,
  // Status
  output logic [5:0] flags,
  output logic skip,
  output logic busy
);
  alu_state_t state;
  logic [W-1:0] operand_b;
  logic [W-1:0] math_a;
  logic [W-1:0] math_b;
  logic math_cin;
  logic math_sub;
  logic [W-1:0] math_res;
  logic math_c;
  logic math_h;
  logic math_v;
  logic [W-1:0] low_result;
  logic word_sub;
  logic word_low_zero;
  logic is_arith;
  logic is_logic;
  logic [W-1:0] logic_res;
  logic io_in_range;
  logic [W-1:0] bit_onehot;

  function automatic logic [W-1:0] onehot(input logic [2:0] sel);
    onehot = {{(W-1){1'b0}}, 1'b1} << sel;
  endfunction

  function automatic logic is_word(input alu_op_t op);
    is_word = (op == ALU_OP_WORD_ADD || op == ALU_OP_WORD_SUB);
  endfunction

  assign operand_b = use_constant ? constant : source_register;
  assign is_arith = op_code inside {ALU_OP_ADD, ALU_OP_ADD_CARRY, ALU_OP_SUB, ALU_OP_SUB_BORROW};
  assign is_logic = op_code inside {ALU_OP_AND, ALU_OP_OR, ALU_OP_XOR};
  // Bit ops cannot reach above the low window
  assign io_in_range = io_addr <= IOW'(`ALU_IO_BIT_MAX);
  assign bit_onehot = onehot(bit_sel);

  ////////////////////////////////////////////////////////////////////////////
  // Shared adder: byte ops, then the two halves of a word op
  always_comb
  begin
    if (state == ALU_ST_WORD_HIGH)
    begin
      math_a = dest_value;
      math_b = '0;
      math_cin = flags[`ALU_FLAG_C];
      math_sub = word_sub;
    end
    else
    begin
      math_a = dest_value;
      // Word ops always take the instruction constant, whatever use_constant says
      math_b = is_word(op_code) ? constant : operand_b;
      math_cin = (op_code == ALU_OP_ADD_CARRY || op_code == ALU_OP_SUB_BORROW)
        ? flags[`ALU_FLAG_C] : 1'b0;
      math_sub = op_code inside {ALU_OP_SUB, ALU_OP_SUB_BORROW, ALU_OP_WORD_SUB};
    end
  end

  alu_byte_math #(.W(W)) u_math (
    .a(math_a),
    .b(math_b),
    .carry_in(math_cin),
    .subtract(math_sub),
    .result(math_res),
    .carry_out(math_c),
    .half_out(math_h),
    .overflow_out(math_v)
  );

  always_comb
  begin
    unique case (op_code)
      ALU_OP_AND: logic_res = dest_value & operand_b;
      ALU_OP_OR: logic_res = dest_value | operand_b;
      ALU_OP_XOR: logic_res = dest_value ^ source_register;
      default: logic_res = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing of two-clock word ops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ALU_ST_IDLE;
      word_sub <= 1'b0;
      word_low_zero <= 1'b0;
      low_result <= '0;
    end
    else if (clk_en)
    begin
      unique case (state)
        ALU_ST_IDLE:
          if (op_valid && is_word(op_code))
          begin
            state <= ALU_ST_WORD_HIGH;
            word_sub <= (op_code == ALU_OP_WORD_SUB);
            word_low_zero <= (math_res == '0);
            low_result <= math_res;
          end
        ALU_ST_WORD_HIGH:
          state <= ALU_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and flags
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_we <= 1'b0;
      reg_we_high <= 1'b0;
      reg_wdata <= '0;
      flags <= `ALU_FLAGS_RESET;
    end
    else if (clk_en)
    begin
      reg_we <= 1'b0;
      reg_we_high <= 1'b0;
      if (state == ALU_ST_WORD_HIGH)
      begin
        reg_we_high <= 1'b1;
        reg_wdata <= math_res;
        // Carry held from the low half feeds the high half
        flags[`ALU_FLAG_C] <= math_c;
        flags[`ALU_FLAG_Z] <= word_low_zero && (math_res == '0);
        flags[`ALU_FLAG_N] <= math_res[W-1];
        flags[`ALU_FLAG_V] <= math_v;
        flags[`ALU_FLAG_S] <= math_res[W-1] ^ math_v;
      end
      else if (op_valid && is_word(op_code))
      begin
        reg_we <= 1'b1;
        reg_wdata <= math_res;
        flags[`ALU_FLAG_C] <= math_c;
      end
      else if (op_valid && is_arith)
      begin
        reg_we <= 1'b1;
        reg_wdata <= math_res;
        flags[`ALU_FLAG_C] <= math_c;
        flags[`ALU_FLAG_Z] <= (math_res == '0);
        flags[`ALU_FLAG_N] <= math_res[W-1];
        flags[`ALU_FLAG_V] <= math_v;
        flags[`ALU_FLAG_H] <= math_h;
      end
      else if (op_valid && is_logic)
      begin
        reg_we <= 1'b1;
        reg_wdata <= logic_res;
        flags[`ALU_FLAG_Z] <= (logic_res == '0);
        flags[`ALU_FLAG_N] <= logic_res[W-1];
        flags[`ALU_FLAG_V] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/O bit set, clear and test
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_we <= 1'b0;
      io_waddr <= '0;
      io_wdata <= '0;
      io_wmask <= '0;
      skip <= 1'b0;
    end
    else if (clk_en)
    begin
      io_we <= 1'b0;
      skip <= 1'b0;
      if (op_valid && state == ALU_ST_IDLE && io_in_range)
      begin
        if (op_code == ALU_OP_SET_IO_BIT || op_code == ALU_OP_CLEAR_IO_BIT)
        begin
          io_we <= 1'b1;
          io_waddr <= io_addr;
          // Only the target lane is enabled, so no flag is written back
          io_wmask <= bit_onehot;
          // A one written to a clear-on-one flag lane clears it; zeros elsewhere
          io_wdata <= (op_code == ALU_OP_SET_IO_BIT) ? bit_onehot : '0;
        end
        if (op_code == ALU_OP_SKIP_IO_SET)
          skip <= |(io_read_data & bit_onehot);
        if (op_code == ALU_OP_SKIP_IO_CLEAR)
          skip <= ~|(io_read_data & bit_onehot);
      end
    end
  end

  assign busy = (state == ALU_ST_WORD_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_add_result: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_ADD && !use_constant
    |=> reg_we && reg_wdata == W'($past(dest_value) + $past(source_register)))
    else $error("add result wrong");
  chk_sub_borrow: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_SUB_BORROW
    |=> reg_wdata == W'($past(dest_value) - $past(operand_b) - W'($past(flags[`ALU_FLAG_C]))))
    else $error("borrow subtract wrong");
  chk_sub_const: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_SUB && use_constant
    |=> reg_wdata == W'($past(dest_value) - $past(constant)))
    else $error("constant subtract wrong");
  chk_word_two: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_WORD_ADD
    |=> reg_we && busy ##1 (!$past(clk_en) || reg_we_high))
    else $error("word op not two clocks");
  chk_and_carry: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_AND
    |=> $stable(flags[`ALU_FLAG_C]) && !flags[`ALU_FLAG_V])
    else $error("and touched carry");
  chk_or_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && op_valid && !busy && op_code == ALU_OP_OR
    |=> flags[`ALU_FLAG_Z] == (reg_wdata == '0) && $stable(flags[`ALU_FLAG_H]))
    else $error("or flags wrong");
  chk_io_range: assert property (@(posedge sys_clk) disable iff (!rstn)
    io_we |-> io_waddr <= IOW'(`ALU_IO_BIT_MAX))
    else $error("bit write out of range");
  chk_one_lane: assert property (@(posedge sys_clk) disable iff (!rstn)
    io_we |-> $onehot(io_wmask) && (io_wdata & ~io_wmask) == '0)
    else $error("bit op touched other lanes");
  chk_sign_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(busy) && $past(clk_en)
    |-> flags[`ALU_FLAG_S] == (flags[`ALU_FLAG_N] ^ flags[`ALU_FLAG_V]))
    else $error("sign flag wrong");
endmodule

// *** alu_io_model.sv ***
`timescale 1ns/1ps
module alu_io_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // I/O side of the datapath
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic [5:0] io_waddr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_wmask,
  output logic [7:0] io_read_data,
  output logic [7:0] io_w1c_mask
);
  // Odd addresses hold flags in the top nibble that clear on a written one
  logic [7:0] mem [64];
  logic [7:0] wm, keep, hit;
  assign io_read_data = mem[io_addr];
  assign io_w1c_mask = io_addr[0] ? 8'hF0 : 8'h00;
  assign wm = io_waddr[0] ? 8'hF0 : 8'h00;
  assign keep = io_wmask & ~wm;
  assign hit = io_wdata & io_wmask & wm;
  ////////////////////////////////////////////////////////////////////////////////
  // Unmasked lanes never move, so a whole-byte write-back would show here
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 64; i++)
        mem[i] <= 8'hA5 ^ 8'(i);
    end
    // Every modelled address is in use, so no write lands on a reserved one
    else if (io_we)
      mem[io_waddr] <= ((mem[io_waddr] & ~keep) | (io_wdata & keep)) & ~hit;
  end
endmodule

// *** alu_pkg.sv ***
package alu_pkg;
  typedef enum logic [3:0] {
    ALU_OP_NONE,
    ALU_OP_ADD,
    ALU_OP_ADD_CARRY,
    ALU_OP_SUB,
    ALU_OP_SUB_BORROW,
    ALU_OP_AND,
    ALU_OP_OR,
    ALU_OP_XOR,
    ALU_OP_WORD_ADD,
    ALU_OP_WORD_SUB,
    ALU_OP_SET_IO_BIT,
    ALU_OP_CLEAR_IO_BIT,
    ALU_OP_SKIP_IO_SET,
    ALU_OP_SKIP_IO_CLEAR
  } alu_op_t;
  typedef enum logic {
    ALU_ST_IDLE,
    ALU_ST_WORD_HIGH
  } alu_state_t;
endpackage

// *** tb.sv ***
`timescale 1ns/1ps
module tb
  import alu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  logic use_constant = 1'b0;
  alu_op_t op_code = ALU_OP_NONE;
  logic [7:0] constant = 8'h00;
  logic [7:0] dest_value = 8'h00;
  logic [7:0] source_register = 8'h00;
  logic [7:0] pair_high = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_read_data, io_w1c_mask, reg_wdata, io_wdata, io_wmask, er;
  logic [5:0] io_waddr, flags, ef;
  logic reg_we, reg_we_high, io_we, skip, busy;
  logic [7:0] exp_io [64];
  int unsigned n;
  integer seed = 93;
  integer mismatches = 0;
  integer comparisons = 0;
  alu_op_t ops [7] = '{ALU_OP_ADD, ALU_OP_ADD_CARRY, ALU_OP_SUB, ALU_OP_SUB_BORROW,
    ALU_OP_AND, ALU_OP_OR, ALU_OP_XOR};
  alu_datapath uut (.sys_clk, .rstn, .clk_en, .op_valid, .op_code, .use_constant, .constant,
    .bit_sel, .io_addr, .dest_value, .source_register, .pair_high, .io_read_data, .io_w1c_mask,
    .reg_we, .reg_we_high, .reg_wdata, .io_we, .io_waddr, .io_wdata, .io_wmask, .flags, .skip,
    .busy);
  alu_io_model pm (.sys_clk, .rstn, .io_addr, .io_we, .io_waddr, .io_wdata, .io_wmask,
    .io_read_data, .io_w1c_mask);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    #200000;
    mismatches = mismatches + 1;
    test_done();
  end
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  task automatic chk(input logic ok, input string m);
    comparisons = comparisons + 1;
    if (ok !== 1'b1)
    begin
      mismatches = mismatches + 1;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic void calc(input alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic ci, sub;
    logic [8:0] s;
    logic [4:0] h;
    ci = (op == ALU_OP_ADD_CARRY || op == ALU_OP_SUB_BORROW) & ef[0];
    sub = op inside {ALU_OP_SUB, ALU_OP_SUB_BORROW};
    s = sub ? a - b - ci : a + b + ci;
    h = sub ? a[3:0] - b[3:0] - ci : a[3:0] + b[3:0] + ci;
    case (op)
      ALU_OP_AND: s = {1'b0, a & b};
      ALU_OP_OR: s = {1'b0, a | b};
      ALU_OP_XOR: s = {1'b0, a ^ b};
      default: ef[3] = (sub ? a[7] != b[7] : a[7] == b[7]) && s[7] != a[7];
    endcase
    er = s[7:0];
    ef[1] = er == 8'h00;
    ef[2] = er[7];
    if (op inside {ALU_OP_AND, ALU_OP_OR, ALU_OP_XOR})
      ef[3] = 1'b0;
    else
    begin
      ef[0] = s[8];
      ef[5] = h[4];
    end
  endfunction
  task automatic byte_op(input alu_op_t op, input logic uc, input logic [7:0] a,
    input logic [7:0] s, input logic [7:0] k);
    op_code = op;
    use_constant = uc;
    dest_value = a;
    source_register = s;
    constant = k;
    op_valid = 1'b1;
    calc(op, a, (uc && op != ALU_OP_XOR) ? k : s);
    @(negedge sys_clk);
    chk(reg_we === 1'b1 && reg_wdata === er, "byte result");
    chk(flags === ef, "byte flags");
  endtask
  // A request held up while busy must be ignored
  task automatic word_op(input alu_op_t op, input logic [7:0] lo, input logic [7:0] hi,
    input logic [5:0] k);
    logic [16:0] r;
    r = (op == ALU_OP_WORD_SUB) ? {hi, lo} - k : {hi, lo} + k;
    ef[0] = r[16];
    ef[1] = r[15:0] == 16'h0000;
    ef[2] = r[15];
    ef[3] = (op == ALU_OP_WORD_SUB) ? hi[7] & ~r[15] : ~hi[7] & r[15];
    ef[4] = ef[2] ^ ef[3];
    op_code = op;
    use_constant = 1'b1;
    constant = {2'h0, k};
    dest_value = lo;
    op_valid = 1'b1;
    @(negedge sys_clk);
    chk(reg_we === 1'b1 && reg_wdata === r[7:0] && busy === 1'b1, "word low");
    dest_value = hi;
    op_code = ALU_OP_ADD;
    @(negedge sys_clk);
    chk(reg_we_high === 1'b1 && reg_we === 1'b0 && reg_wdata === r[15:8], "word high");
    chk(flags === ef && busy === 1'b0, "word flags");
    op_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic bit_op(input alu_op_t op, input logic [5:0] a, input logic [2:0] b);
    logic [7:0] m, w;
    logic wr, sk;
    m = 8'h01 << b;
    w = a[0] ? 8'hF0 : 8'h00;
    wr = a <= 6'h1F && op inside {ALU_OP_SET_IO_BIT, ALU_OP_CLEAR_IO_BIT};
    sk = (exp_io[a] & m) != 8'h00;
    sk = a <= 6'h1F && (op == ALU_OP_SKIP_IO_SET ? sk : op == ALU_OP_SKIP_IO_CLEAR && !sk);
    if (wr && op == ALU_OP_SET_IO_BIT)
      exp_io[a] = ((w & m) != 8'h00) ? exp_io[a] & ~m : exp_io[a] | m;
    else if (wr && (w & m) == 8'h00)
      exp_io[a] = exp_io[a] & ~m;
    op_code = op;
    io_addr = a;
    bit_sel = b;
    op_valid = 1'b1;
    @(negedge sys_clk);
    chk(io_we === wr && skip === sk && reg_we === 1'b0 && flags === ef, "io bit op");
    if (wr)
      chk(io_waddr === a && io_wmask === m, "io lane");
    if (wr)
      chk(io_wdata[b] === (op == ALU_OP_SET_IO_BIT), "io data");
    op_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 64; i++)
      exp_io[i] = 8'hA5 ^ 8'(i);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    ef = 6'h00;
    @(negedge sys_clk);
    chk(flags === 6'h00 && reg_we === 1'b0 && busy === 1'b0, "reset state");
    byte_op(ALU_OP_ADD, 1'b0, 8'h80, 8'h80, 8'h00);
    byte_op(ALU_OP_ADD_CARRY, 1'b0, 8'h0F, 8'h00, 8'h00);
    byte_op(ALU_OP_SUB, 1'b1, 8'h00, 8'h00, 8'h01);
    byte_op(ALU_OP_SUB_BORROW, 1'b1, 8'h05, 8'h00, 8'h04);
    byte_op(ALU_OP_AND, 1'b1, 8'hF0, 8'h00, 8'h0F);
    byte_op(ALU_OP_XOR, 1'b1, 8'h55, 8'hAA, 8'h55);
    byte_op(ALU_OP_SUB_BORROW, 1'b0, 8'h80, 8'h01, 8'h00);
    repeat (150)
    begin
      n = $random(seed);
      byte_op(ops[n % 7], n[8], rnd(), rnd(), rnd());
    end
    clk_en = 1'b0;
    op_code = ALU_OP_ADD;
    use_constant = 1'b0;
    dest_value = 8'h01;
    source_register = 8'h02;
    repeat (2) @(negedge sys_clk);
    chk(reg_wdata === er && flags === ef, "frozen");
    calc(ALU_OP_ADD, 8'h01, 8'h02);
    clk_en = 1'b1;
    @(negedge sys_clk);
    chk(reg_wdata === er && flags === ef, "thawed");
    word_op(ALU_OP_WORD_ADD, 8'hFF, 8'hFF, 6'h01);
    word_op(ALU_OP_WORD_SUB, 8'h00, 8'h00, 6'h01);
    word_op(ALU_OP_WORD_ADD, 8'hC3, 8'h7F, 6'h3F);
    repeat (10)
    begin
      n = $random(seed);
      word_op(n[0] ? ALU_OP_WORD_ADD : ALU_OP_WORD_SUB, rnd(), rnd(), n[6:1]);
    end
    bit_op(ALU_OP_SET_IO_BIT, 6'h01, 3'h7);
    bit_op(ALU_OP_CLEAR_IO_BIT, 6'h03, 3'h6);
    bit_op(ALU_OP_SET_IO_BIT, 6'h1F, 3'h0);
    bit_op(ALU_OP_CLEAR_IO_BIT, 6'h20, 3'h1);
    bit_op(ALU_OP_SKIP_IO_SET, 6'h1F, 3'h0);
    bit_op(ALU_OP_SKIP_IO_CLEAR, 6'h01, 3'h7);
    repeat (40)
    begin
      n = $random(seed);
      bit_op(alu_op_t'(4'hA + n[1:0]), n[7:2], n[10:8]);
    end
    for (int i = 0; i < 64; i++)
      chk(pm.mem[i] === exp_io[i], "io contents");
    test_done();
  end
endmodule
